// file: itod_cpu_model.sv
// Processor-side model that issues register transfers the way clock instructions would.
`timescale 1ns/10ps
module itod_cpu_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; waits on hready in both phases, so wait states are tolerated.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hsel   <= 1'h0;
    // On reads the data lines carry a changing pattern so stale data never matches.
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
endmodule // itod_cpu_model

// file: itod_pkg.sv
// Constants, register map and carrier types of the interval timer and time-of-day clock.
package itod_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TOD_STEP_NS   = 1000;
  localparam int unsigned TOD_STEP_CYC  = TOD_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned ITMR_STEP_US  = 3300;
  localparam int unsigned ITMR_STEP_CYC = ITMR_STEP_US * 1000 / CLK_PERIOD_NS;

  localparam int unsigned TOD_W = 52;

  // One interval step is bit 8 of the timer word, so bits 31:8 give 2**24 steps.
  localparam logic [31:0] ITMR_STEP = 32'h0000_0100;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_SET_HI   = 8'h10;
  localparam logic [7:0] OFS_SET_LO   = 8'h14;
  localparam logic [7:0] OFS_CMD      = 8'h18;
  localparam logic [7:0] OFS_SNAP_HI  = 8'h1C;
  localparam logic [7:0] OFS_SNAP_LO  = 8'h20;
  localparam logic [7:0] OFS_ITMR     = 8'h50;

  localparam int unsigned CTRL_EXT_MASK = 0;
  localparam int unsigned CTRL_ITMR_SUB = 1;
  localparam int unsigned CTRL_SUPV     = 2;

  localparam int unsigned CMD_SET   = 0;
  localparam int unsigned CMD_STORE = 1;

  localparam int unsigned EV_W        = 5;
  localparam int unsigned EV_ITMR     = 0;
  localparam int unsigned EV_SET_DONE = 1;
  localparam int unsigned EV_SET_REF  = 2;
  localparam int unsigned EV_INVAL    = 3;
  localparam int unsigned EV_STORE    = 4;

  localparam logic [2:0]    CTRL_RST = 3'h0;
  localparam logic [31:0]   ITMR_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       vld;
  } itod_aph_t;

endpackage

// file: itod_tick.sv
// Free-running divider that emits a one-cycle tick every PERIOD clock cycles.
`timescale 1ns/10ps
module itod_tick #(
  parameter int unsigned PERIOD = 250
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);

  localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= (cnt_ff == LAST) ? '0 : cnt_ff + CW'(1);
      tick_ff <= (cnt_ff == LAST);
    end
  end

  assign tick = tick_ff;

endmodule // itod_tick

// file: itod_timer.sv
// Interval timer and 52-bit time-of-day clock behind an AHB-Lite register slave.
//
// What this block does
// - The interval timer word sits at byte address 80 and reads and writes like storage.
// - The interval timer steps once every 3.3 milliseconds.
// - The timer word holds 2**24 steps, about 15.4 hours, before it wraps.
// - The time-of-day clock is a free-running 52-bit binary counter spanning about 143 years.
// - The time-of-day counter advances by one every microsecond.
// - A store command captures the counter into a doubleword and a set command loads a new time.
// - A set takes effect only in supervisor state with the security switch enabled.
// - The time-of-day counter runs whether the processor runs or stops.
// - Test modes, clock errors and microdiagnostics mark the time-of-day value invalid.
// - The interval timer does not advance while the system is stopped.
// - Under excessive activity an interval timer update may be skipped.
// - The itimer_irq interrupt needs both the external mask and the timer subclass mask set; irq needs only the timer bit of the interrupt mask register.
`timescale 1ns/10ps
module itod_timer #(
  parameter int unsigned ITMR_CYC = itod_pkg::ITMR_STEP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sys_stopped,
  input  wire logic        clock_sec_en,
  input  wire logic        test_mode,
  input  wire logic        clock_error,
  input  wire logic        microdiag_run,
  input  wire logic        busy_excess,
  output logic             irq,
  output logic             itimer_irq
);

  localparam int unsigned TW = itod_pkg::TOD_W;

  itod_pkg::itod_aph_t       aph_ff;
  logic [31:0]               hrdata_ff;
  logic [2:0]                ctrl_ff;
  logic [itod_pkg::EV_W-1:0] stat_ff;
  logic [itod_pkg::EV_W-1:0] mask_ff;
  logic [itod_pkg::EV_W-1:0] ev;
  logic [TW-1:0]             tod_ff;
  logic [TW-1:0]             set_val_ff;
  logic [TW-1:0]             snap_ff;
  logic                      snap_inv_ff;
  logic                      tod_inval_ff;
  logic [31:0]               itmr_ff;
  logic [31:0]               nxt_itmr;
  logic                      irq_ff;
  logic                      itimer_irq_ff;
  logic                      hreadyout_ff;
  logic                      us_tick;
  logic                      it_tick;
  logic                      wr_go;
  logic                      wr_itmr;
  logic                      cmd_set;
  logic                      set_go;
  logic                      set_ref;
  logic                      store_go;
  logic                      itmr_dec;
  logic                      inval_src;
  logic [31:0]               rd_mux;

  itod_tick #(.PERIOD(itod_pkg::TOD_STEP_CYC)) u_us_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (us_tick)
  );

  itod_tick #(.PERIOD(ITMR_CYC)) u_it_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (it_tick)
  );

  // The slave never waits, so every transfer completes in its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= '0;
    end else if (hready) begin
      aph_ff.vld  <= hsel & htrans[1];
      aph_ff.wr   <= hwrite;
      aph_ff.addr <= haddr[7:0];
    end
  end

  assign wr_go    = aph_ff.vld & aph_ff.wr;
  assign wr_itmr  = wr_go & (aph_ff.addr == itod_pkg::OFS_ITMR);
  assign cmd_set  = wr_go & (aph_ff.addr == itod_pkg::OFS_CMD) & hwdata[itod_pkg::CMD_SET];
  assign set_go   = cmd_set & ctrl_ff[itod_pkg::CTRL_SUPV] & clock_sec_en;
  assign set_ref  = cmd_set & ~set_go;
  assign store_go = wr_go & (aph_ff.addr == itod_pkg::OFS_CMD) & hwdata[itod_pkg::CMD_STORE];
  assign inval_src = test_mode | clock_error | microdiag_run;

  // A stopped system or a busy one simply loses the step; the tick is not banked.
  assign itmr_dec = it_tick & ~sys_stopped & ~busy_excess;
  assign nxt_itmr = itmr_ff - itod_pkg::ITMR_STEP;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      itod_pkg::OFS_CTRL:     rd_mux = {29'h0, ctrl_ff};
      itod_pkg::OFS_STATUS:   rd_mux = {29'h0, snap_inv_ff, clock_sec_en, tod_inval_ff};
      itod_pkg::OFS_IRQ_STAT: rd_mux = {27'h0, stat_ff};
      itod_pkg::OFS_IRQ_MASK: rd_mux = {27'h0, mask_ff};
      itod_pkg::OFS_SET_HI:   rd_mux = {12'h0, set_val_ff[TW-1:32]};
      itod_pkg::OFS_SET_LO:   rd_mux = set_val_ff[31:0];
      itod_pkg::OFS_SNAP_HI:  rd_mux = {12'h0, snap_ff[TW-1:32]};
      itod_pkg::OFS_SNAP_LO:  rd_mux = snap_ff[31:0];
      itod_pkg::OFS_ITMR:     rd_mux = itmr_ff;
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff    <= itod_pkg::CTRL_RST;
      mask_ff    <= itod_pkg::MASK_RST;
      set_val_ff <= '0;
    end else if (wr_go) begin
      case (aph_ff.addr)
        itod_pkg::OFS_CTRL:     ctrl_ff <= hwdata[2:0];
        itod_pkg::OFS_IRQ_MASK: mask_ff <= hwdata[itod_pkg::EV_W-1:0];
        itod_pkg::OFS_SET_HI:   set_val_ff[TW-1:32] <= hwdata[TW-33:0];
        itod_pkg::OFS_SET_LO:   set_val_ff[31:0] <= hwdata;
        default: ;
      endcase
    end
  end

  // The counter never looks at sys_stopped; only a permitted set disturbs it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tod_ff <= '0;
    end else if (set_go) begin
      tod_ff <= set_val_ff;
    end else if (us_tick) begin
      tod_ff <= tod_ff + TW'(1);
    end
  end

  // Power-on leaves the time unknown, so the mark starts set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tod_inval_ff <= 1'b1;
    end else if (inval_src) begin
      tod_inval_ff <= 1'b1;
    end else if (set_go) begin
      tod_inval_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_ff     <= '0;
      snap_inv_ff <= 1'b1;
    end else if (store_go) begin
      snap_ff     <= tod_ff;
      snap_inv_ff <= tod_inval_ff;
    end
  end

  // A software load of the timer word wins over a step in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      itmr_ff <= itod_pkg::ITMR_RST;
    end else if (wr_itmr) begin
      itmr_ff <= hwdata;
    end else if (itmr_dec) begin
      itmr_ff <= nxt_itmr;
    end
  end

  always_comb begin
    ev = '0;
    ev[itod_pkg::EV_ITMR]     = itmr_dec & ~wr_itmr & ~itmr_ff[31] & nxt_itmr[31];
    ev[itod_pkg::EV_SET_DONE] = set_go;
    ev[itod_pkg::EV_SET_REF]  = set_ref;
    ev[itod_pkg::EV_INVAL]    = inval_src & ~tod_inval_ff;
    ev[itod_pkg::EV_STORE]    = store_go;
  end

  // New events win over a write-one-to-clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_ff <= '0;
    end else if (wr_go && aph_ff.addr == itod_pkg::OFS_IRQ_STAT) begin
      stat_ff <= (stat_ff & ~hwdata[itod_pkg::EV_W-1:0]) | ev;
    end else begin
      stat_ff <= stat_ff | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff        <= 1'b0;
      itimer_irq_ff <= 1'b0;
    end else begin
      irq_ff        <= |(stat_ff & mask_ff);
      itimer_irq_ff <= stat_ff[itod_pkg::EV_ITMR] & ctrl_ff[itod_pkg::CTRL_EXT_MASK]
                       & ctrl_ff[itod_pkg::CTRL_ITMR_SUB];
    end
  end

  // Ready comes from a flop so the bus never sees the reset pin routed straight to an output.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  assign hrdata     = hrdata_ff;
  assign hreadyout  = hreadyout_ff;
  assign hresp      = 1'b0;
  assign irq        = irq_ff;
  assign itimer_irq = itimer_irq_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_itmr_cross;
    itmr_dec && !wr_itmr && !itmr_ff[31] && nxt_itmr[31];
  endsequence

  sequence s_us_step;
    us_tick && !set_go;
  endsequence

  a_itmr_read: assert property (
    (hready && hsel && htrans[1] && !hwrite && haddr[7:0] == itod_pkg::OFS_ITMR)
    |=> hrdata_ff == $past(itmr_ff))
    else $error("Timer word read returned a stale value.");

  a_tod_step: assert property (
    s_us_step |=> tod_ff == $past(tod_ff) + TW'(1))
    else $error("Clock did not advance on its microsecond tick.");

  a_tod_period: assert property (
    us_tick |=> !us_tick [*8])
    else $error("Microsecond ticks came too close together.");

  a_tod_stopped: assert property (
    s_us_step ##0 sys_stopped |=> tod_ff != $past(tod_ff))
    else $error("Clock halted while the system was stopped.");

  a_set_gate: assert property (
    cmd_set && !(ctrl_ff[itod_pkg::CTRL_SUPV] && clock_sec_en)
    |=> stat_ff[itod_pkg::EV_SET_REF] && $stable(set_val_ff)
    && (tod_ff == $past(tod_ff) || tod_ff == $past(tod_ff) + TW'(1)))
    else $error("Refused set altered the clock.");

  a_set_load: assert property (
    set_go |=> tod_ff == $past(set_val_ff))
    else $error("Permitted set did not load the new time.");

  a_store_snap: assert property (
    store_go |=> snap_ff == $past(tod_ff) && snap_inv_ff == $past(tod_inval_ff))
    else $error("Store command did not capture the clock.");

  a_inval_mark: assert property (
    inval_src |=> tod_inval_ff)
    else $error("Invalidating condition did not mark the clock.");

  a_set_valid: assert property (
    set_go && !inval_src |=> !tod_inval_ff)
    else $error("Successful set left the clock marked invalid.");

  a_itmr_hold: assert property (
    (sys_stopped || busy_excess) && !wr_itmr |=> $stable(itmr_ff))
    else $error("Timer word moved while stopped or skipping.");

  a_itmr_step: assert property (
    itmr_dec && !wr_itmr |=> itmr_ff == $past(itmr_ff) - itod_pkg::ITMR_STEP)
    else $error("Timer word did not drop by one step.");

  a_itmr_cross: assert property (
    s_itmr_cross |=> stat_ff[itod_pkg::EV_ITMR]
    ##1 (irq_ff || !$past(mask_ff[itod_pkg::EV_ITMR])))
    else $error("Timer sign change did not raise its flag.");

  a_itmr_mask: assert property (
    !ctrl_ff[itod_pkg::CTRL_EXT_MASK] || !ctrl_ff[itod_pkg::CTRL_ITMR_SUB]
    |=> !itimer_irq_ff)
    else $error("Timer interrupt escaped its masks.");

endmodule // itod_timer

// file: test_interval_timer_time_of_day_clock.sv
// Self-checking testbench of the interval timer and time-of-day clock.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_interval_timer_time_of_day_clock;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        sys_stopped = 1'h0;
  logic        clock_sec_en = 1'h0;
  logic        test_mode = 1'h0;
  logic        clock_error = 1'h0;
  logic        microdiag_run = 1'h0;
  logic        busy_excess = 1'h0;
  wire         hsel, hwrite, hready, hresp, irq, itimer_irq;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  logic [31:0] rdv;
  int          bad_count = 0;
  int          num_checks = 0;

  always #2 hclk = ~hclk;

  itod_cpu_model itod_cpu_model_inst (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // A short step keeps the run brief; every timer word expectation below is in steps of 20 cycles.
  itod_timer #(.ITMR_CYC(20)) itod_timer_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .sys_stopped(sys_stopped), .clock_sec_en(clock_sec_en),
    .test_mode(test_mode), .clock_error(clock_error), .microdiag_run(microdiag_run),
    .busy_excess(busy_excess), .irq(irq), .itimer_irq(itimer_irq));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    itod_cpu_model_inst.xfer(1'h1, a, d, rdv);
  endtask

  task automatic rd(input logic [7:0] a);
    itod_cpu_model_inst.xfer(1'h0, a, 32'h0, rdv);
  endtask

  task automatic snap(output logic [51:0] v);
    wr(itod_pkg::OFS_CMD, 32'h2);
    rd(itod_pkg::OFS_SNAP_HI);
    v[51:32] = rdv[19:0];
    rd(itod_pkg::OFS_SNAP_LO);
    v[31:0] = rdv;
  endtask

  task automatic t_reset();
    rd(itod_pkg::OFS_ITMR);
    `CHK(rdv, 32'h0)
    rd(itod_pkg::OFS_STATUS);
    `CHK(rdv[1:0], 2'h1)
    rd(8'h40);
    `CHK(rdv, 32'h0)
    `CHK(hresp, 1'h0)
  endtask

  task automatic t_set_refused();
    for (int i = 0; i < 2; i++) begin
      clock_sec_en <= i[0];
      wr(itod_pkg::OFS_CTRL, i[0] ? 32'h0 : 32'h4);
      wr(itod_pkg::OFS_IRQ_STAT, 32'h1F);
      wr(itod_pkg::OFS_CMD, 32'h1);
      rd(itod_pkg::OFS_IRQ_STAT);
      `CHK(rdv[2:1], 2'h2)
      rd(itod_pkg::OFS_STATUS);
      `CHK(rdv[1:0], {i[0], 1'h1})
    end
  endtask

  task automatic t_set_run();
    logic [51:0] v0;
    logic [51:0] v1;
    clock_sec_en <= 1'h1;
    wr(itod_pkg::OFS_CTRL, 32'h4);
    wr(itod_pkg::OFS_SET_HI, 32'h000F_FFFF);
    wr(itod_pkg::OFS_SET_LO, 32'hFFFF_FFFE);
    wr(itod_pkg::OFS_CMD, 32'h1);
    rd(itod_pkg::OFS_STATUS);
    `CHK(rdv[0], 1'h0)
    rd(itod_pkg::OFS_IRQ_STAT);
    `CHK(rdv[1], 1'h1)
    sys_stopped <= 1'h1;
    // The two stores commit exactly 2500 cycles apart: snap itself spans 9 edges.
    snap(v0);
    repeat (2491) @(posedge hclk);
    snap(v1);
    `CHK(v1 - v0, 52'hA)
    `CHK(v1 < 52'h10, 1'b1)
    `CHK(v0 > 52'hF_FFFF_FFFF_FFF0, 1'b1)
    rd(itod_pkg::OFS_STATUS);
    `CHK(rdv[2], 1'h0)
    rd(itod_pkg::OFS_IRQ_STAT);
    `CHK(rdv[4], 1'h1)
  endtask

  task automatic t_invalidate();
    for (int i = 0; i < 3; i++) begin
      wr(itod_pkg::OFS_CMD, 32'h1);
      wr(itod_pkg::OFS_IRQ_STAT, 32'h1F);
      {microdiag_run, clock_error, test_mode} <= 3'h1 << i;
      @(posedge hclk);
      {microdiag_run, clock_error, test_mode} <= 3'h0;
      rd(itod_pkg::OFS_STATUS);
      `CHK(rdv[0], 1'h1)
      rd(itod_pkg::OFS_IRQ_STAT);
      `CHK(rdv[3], 1'h1)
    end
  endtask

  task automatic t_itimer();
    int n;
    sys_stopped <= 1'h0;
    wr(itod_pkg::OFS_CTRL, 32'h7);
    wr(itod_pkg::OFS_IRQ_MASK, 32'h1);
    wr(itod_pkg::OFS_IRQ_STAT, 32'h1F);
    wr(itod_pkg::OFS_ITMR, 32'h200);
    n = 0;
    while (itimer_irq !== 1'h1 && n < 200) begin
      @(posedge hclk);
      #1;
      n++;
    end
    `CHK(irq, 1'h1)
    rd(itod_pkg::OFS_ITMR);
    `CHK(rdv, 32'hFFFF_FF00)
    wr(itod_pkg::OFS_CTRL, 32'h6);
    @(posedge hclk);
    #1;
    `CHK(itimer_irq, 1'h0)
    `CHK(irq, 1'h1)
    wr(itod_pkg::OFS_IRQ_STAT, 32'h1);
    @(posedge hclk);
    #1;
    `CHK(irq, 1'h0)
  endtask

  task automatic t_freeze();
    for (int i = 0; i < 3; i++) begin
      {busy_excess, sys_stopped} <= 2'h1 << i;
      wr(itod_pkg::OFS_ITMR, 32'h1000);
      repeat (45) @(posedge hclk);
      rd(itod_pkg::OFS_ITMR);
      if (i < 2) begin
        `CHK(rdv, 32'h1000)
      end else begin
        `CHK(rdv == 32'hE00 || rdv == 32'hD00, 1'b1)
      end
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_set_refused();
    t_set_run();
    t_invalidate();
    t_itimer();
    t_freeze();
    final_report();
  end
endmodule // test_interval_timer_time_of_day_clock
